// file: verilog/b4sram_pkg.sv
// Purpose: shared constants for the four-word burst SRAM link
// Assumes: one link clock rise per data beat, kPhase marks true rises
// Notes:   beat counts are link clock rises after the start rise
package b4sram_pkg;
   localparam int LANE_W        = 9;
   localparam int MAX_LANES     = 4;
   localparam int BURST_LEN     = 4;
   localparam int WR_FIRST_BEAT = 2;   // rise t+2 true
   localparam int RD_FIRST_BEAT = 3;   // rise t+3 complement
   localparam int HIST_W        = 7;
   localparam int PREV_START    = 1;   // history bit of previous true rise
   localparam int DEF_DATA_W    = 18;
   localparam int DEF_ADDR_W    = 4;
   localparam int FIFO_DEPTH    = 4;
endpackage

// file: verilog/b4sram_link_if.sv
// Purpose: pins between the memory controller and the SRAM device
// Assumes: controller makes linkClk and every other input pin
// Notes:   q is valid only while qOe is high
interface b4sram_link_if #(
   parameter int DATA_W = b4sram_pkg::DEF_DATA_W,
   parameter int ADDR_W = b4sram_pkg::DEF_ADDR_W
);
   localparam int LANES = DATA_W / b4sram_pkg::LANE_W;
   logic              linkClk;
   logic              kPhase;
   logic              readPortSelectN;
   logic              writePortSelectN;
   logic              cTieHigh;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] d;
   logic [LANES-1:0]  byteLaneWriteSelectN;
   logic [DATA_W-1:0] q;
   logic              qOe;
   modport dev (input linkClk, kPhase, readPortSelectN, writePortSelectN,
                cTieHigh, addr, d, byteLaneWriteSelectN,
                output q, qOe);
   modport ctl (output linkClk, kPhase, readPortSelectN, writePortSelectN,
                cTieHigh, addr, d, byteLaneWriteSelectN,
                input q, qOe);
endinterface // b4sram_link_if

// file: verilog/b4sram_device.sv
// Purpose: SRAM end of the link, burst of four, byte lane masking
// Assumes: rst_b held low over at least four link clock rises
// Notes:   storage is flip-flops, depth is two to the ADDR_W
module b4sram_device #(
   parameter int DATA_W = b4sram_pkg::DEF_DATA_W,
   parameter int ADDR_W = b4sram_pkg::DEF_ADDR_W
) (
   b4sram_link_if.dev link,              // link pins, clocked by linkClk
   input  wire logic  rst_b,             // sync reset from the system clock, resynchronised
   output logic       singleClockMode    // strap captured after reset
);
   localparam int LANES = DATA_W / b4sram_pkg::LANE_W;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int HW    = b4sram_pkg::HIST_W;

   if (DATA_W % b4sram_pkg::LANE_W != 0 || LANES < 1 ||
       LANES > b4sram_pkg::MAX_LANES) begin : gBadWidth
      $error("DATA_W must be 9, 18, 27 or 36");
   end

   typedef struct packed {
      logic [DEPTH-1:0][DATA_W-1:0] mem;
      logic [HW-1:0]                rdHist;
      logic [HW-1:0]                wrHist;
      logic [ADDR_W-1:0]            rdPend;
      logic [ADDR_W-1:0]            rdCur;
      logic [ADDR_W-1:0]            wrPend;
      logic [ADDR_W-1:0]            wrCur;
      logic [DATA_W-1:0]            q;
      logic                         qOe;
      logic                         strapDone;
      logic                         single;
      logic [2:0]                   rstSync;
   } b4sram_dev_state_type;

   b4sram_dev_state_type s_q;
   b4sram_dev_state_type s_d;

   always_comb
   begin
      logic [ADDR_W-1:0] base;
      logic              rdStart;
      logic              wrStart;
      logic              live;
      base = '0;
      s_d = s_q;
      // rst_b is launched by the system clock, so it is resynchronised
      s_d.rstSync = {s_q.rstSync[1:0], rst_b};
      live = s_q.rstSync[2] && s_q.rstSync[1];
      s_d.rdHist = {s_q.rdHist[HW-2:0], 1'b0};
      s_d.wrHist = {s_q.wrHist[HW-2:0], 1'b0};
      // a start one true rise after the same kind is dropped silently
      rdStart = link.kPhase && !link.readPortSelectN &&
                !s_q.rdHist[b4sram_pkg::PREV_START];
      // after a read the read select is don't-care, so a write wins
      wrStart = link.kPhase && !link.writePortSelectN &&
                !s_q.wrHist[b4sram_pkg::PREV_START] &&
                !rdStart;
      if (rdStart)
      begin
         s_d.rdHist[0] = 1'b1;
         s_d.rdPend    = link.addr;
      end
      if (wrStart)
      begin
         s_d.wrHist[0] = 1'b1;
         s_d.wrPend    = link.addr;
      end
      // both selects high: nothing starts, d used only by a write burst already in flight
      for (int i = 0; i < b4sram_pkg::BURST_LEN; i++)
      begin
         if (s_q.wrHist[b4sram_pkg::WR_FIRST_BEAT - 1 + i])
         begin
            // pend may be overwritten by the next write from beat four on
            base = (i == 0) ? s_q.wrPend : s_q.wrCur;
            if (i == 0)
            begin
               s_d.wrCur = s_q.wrPend;
            end
            for (int l = 0; l < LANES; l++)
            begin
               // selects taken fresh on every beat
               if (!link.byteLaneWriteSelectN[l])
               begin
                  s_d.mem[base + ADDR_W'(i)][l*b4sram_pkg::LANE_W +:
                     b4sram_pkg::LANE_W] =
                     link.d[l*b4sram_pkg::LANE_W +: b4sram_pkg::LANE_W];
               end
               // all high leaves every lane untouched
            end
         end
      end
      // outputs go off one beat after the last word
      if (s_q.rdHist[b4sram_pkg::RD_FIRST_BEAT + b4sram_pkg::BURST_LEN - 1])
      begin
         s_d.qOe = 1'b0;
      end
      for (int i = 0; i < b4sram_pkg::BURST_LEN; i++)
      begin
         if (s_q.rdHist[b4sram_pkg::RD_FIRST_BEAT - 1 + i])
         begin
            base = (i == 0) ? s_q.rdPend : s_q.rdCur;
            if (i == 0)
            begin
               s_d.rdCur = s_q.rdPend;
            end
            // launched on every rise, single mode or not
            s_d.q   = s_q.mem[base + ADDR_W'(i)];
            s_d.qOe = 1'b1;
         end
      end
      // strap caught once after release, fixed until next reset
      if (!s_q.strapDone)
      begin
         s_d.strapDone = 1'b1;
         s_d.single    = link.cTieHigh;
      end
      if (!live)
      begin
         s_d = '0;
         s_d.rstSync = {s_q.rstSync[1:0], rst_b};
      end
   end

   // no edges while stopped, so every field simply holds
   always_ff @(posedge link.linkClk)
   begin
      s_q <= s_d;
   end

   assign link.q          = s_q.q;
   assign link.qOe        = s_q.qOe;
   assign singleClockMode = s_q.single;
endmodule // b4sram_device

// file: verilog/b4sram_ctrl.sv
// Purpose: memory controller end, command FIFO and link sequencer
// Assumes: clock runs at 200 MHz; link clock is clock divided by two
// Notes:   one command is a whole burst of four words with lane masks
module b4sram_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = b4sram_pkg::FIFO_DEPTH
) (
   input  wire logic             clock,     // system clock
   input  wire logic             rst_b,     // sync reset, active low
   input  wire logic             inValid,   // writer offers a word
   output logic                  inReady,   // room for a word
   input  wire logic [WIDTH-1:0] inData,    // word written
   output logic                  outValid,  // a word is waiting
   input  wire logic             outReady,  // reader takes the word
   output logic      [WIDTH-1:0] outData    // oldest word
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
      $error("DEPTH must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wp;
      logic [PW-1:0]               rp;
      logic [PW:0]                 count;
      logic                        ready;
   } b4sram_fifo_state_type;

   b4sram_fifo_state_type s_q;
   b4sram_fifo_state_type s_d;

   always_comb
   begin
      logic push;
      logic pop;
      push = inValid && s_q.ready;
      pop  = outValid && outReady;
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wp] = inData;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (pop)
      begin
         s_d.rp = s_q.rp + 1'b1;
      end
      s_d.count = s_q.count + (PW+1)'(push) - (PW+1)'(pop);
      // registered so the full flag reaches the port from a flop
      s_d.ready = (s_d.count != (PW+1)'(DEPTH));
      if (!rst_b)
      begin
         s_d = '0;
         s_d.ready = 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      s_q <= s_d;
   end

   assign inReady  = s_q.ready;
   assign outValid = (s_q.count != '0);
   assign outData  = s_q.mem[s_q.rp];
endmodule // b4sram_fifo

module b4sram_ctrl #(
   parameter int DATA_W = b4sram_pkg::DEF_DATA_W,
   parameter int ADDR_W = b4sram_pkg::DEF_ADDR_W,
   localparam int LANES = DATA_W / b4sram_pkg::LANE_W,
   localparam int BW    = b4sram_pkg::BURST_LEN * DATA_W,
   localparam int MW    = b4sram_pkg::BURST_LEN * LANES
) (
   input  wire logic              clock,       // 200 MHz system clock
   input  wire logic              rst_b,       // sync reset, active low
   input  wire logic              clockRun,    // low parks link clock
   input  wire logic              singleClock, // strap level at reset
   input  wire logic              cmdValid,    // burst command offered
   output logic                   cmdReady,    // command FIFO has room
   input  wire logic              cmdWrite,    // 1 write, 0 read
   input  wire logic [ADDR_W-1:0] cmdAddr,     // burst start address
   input  wire logic [BW-1:0]     cmdData,     // word i at [i*DATA_W]
   input  wire logic [MW-1:0]     cmdLaneN,    // lane selects, low writes
   output logic      [DATA_W-1:0] rdData,      // read word
   output logic                   rdValid,     // one pulse per read word
   b4sram_link_if.ctl             link         // link pins
);
   localparam int HW    = b4sram_pkg::HIST_W;
   localparam int CMD_W = 1 + ADDR_W + MW + BW;

   if (DATA_W % b4sram_pkg::LANE_W != 0 || LANES < 1 ||
       LANES > b4sram_pkg::MAX_LANES) begin : gBadWidth
      $error("DATA_W must be 9, 18, 27 or 36");
   end

   typedef struct packed {
      logic                clk;
      logic                phase;
      logic                rdSelN;
      logic                wrSelN;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   d;
      logic [LANES-1:0]    laneN;
      logic [HW-1:0]       rdHist;
      logic [HW-1:0]       wrHist;
      logic [BW-1:0]       pendData;
      logic [MW-1:0]       pendLane;
      logic [BW-1:0]       actData;
      logic [MW-1:0]       actLane;
      logic [DATA_W-1:0]   rdWord;
      logic                rdValid;
      logic                single;
   } b4sram_ctrl_state_type;

   b4sram_ctrl_state_type s_q;
   b4sram_ctrl_state_type s_d;

   logic             fifoValid;
   logic             fifoPop;
   logic [CMD_W-1:0] fifoData;

   b4sram_fifo #(
      .WIDTH (CMD_W),
      .DEPTH (b4sram_pkg::FIFO_DEPTH)
   ) uFifo (
      .clock    (clock),
      .rst_b    (rst_b),
      .inValid  (cmdValid),
      .inReady  (cmdReady),
      .inData   ({cmdWrite, cmdAddr, cmdLaneN, cmdData}),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoData)
   );

   always_comb
   begin
      logic          run;
      logic          tick;
      logic          isWr;
      logic [BW-1:0] data;
      logic [MW-1:0] lane;
      isWr = fifoData[CMD_W-1];
      data = '0;
      lane = '0;
      s_d = s_q;
      fifoPop = 1'b0;
      s_d.rdValid = 1'b0;
      // stop only between bursts, parked high
      run  = clockRun || (s_q.rdHist != '0) || (s_q.wrHist != '0);
      tick = s_q.clk && run;
      if (run || !s_q.clk)
      begin
         s_d.clk = !s_q.clk;
      end
      // pins change half a link period before the rise that samples
      if (tick)
      begin
         s_d.phase  = !s_q.phase;
         s_d.rdHist = {s_q.rdHist[HW-2:0], 1'b0};
         s_d.wrHist = {s_q.wrHist[HW-2:0], 1'b0};
         s_d.rdSelN = 1'b1;
         s_d.wrSelN = 1'b1;
         s_d.laneN  = '1;
         // one start per true rise, never same kind on two true rises in a row
         if (s_d.phase && fifoValid)
         begin
            if (isWr && !s_q.wrHist[b4sram_pkg::PREV_START])
            begin
               fifoPop = 1'b1;
               s_d.wrSelN   = 1'b0;
               s_d.addr     = fifoData[CMD_W-2 -: ADDR_W];
               s_d.pendLane = fifoData[BW +: MW];
               s_d.pendData = fifoData[BW-1:0];
               s_d.wrHist[0] = 1'b1;
            end
            else if (!isWr && !s_q.rdHist[b4sram_pkg::PREV_START])
            begin
               fifoPop = 1'b1;
               s_d.rdSelN   = 1'b0;
               s_d.addr     = fifoData[CMD_W-2 -: ADDR_W];
               s_d.rdHist[0] = 1'b1;
            end
         end
         for (int i = 0; i < b4sram_pkg::BURST_LEN; i++)
         begin
            if (s_q.wrHist[b4sram_pkg::WR_FIRST_BEAT - 1 + i])
            begin
               // pend is reused by a write starting four beats later
               data = (i == 0) ? s_q.pendData : s_q.actData;
               lane = (i == 0) ? s_q.pendLane : s_q.actLane;
               if (i == 0)
               begin
                  s_d.actData = s_q.pendData;
                  s_d.actLane = s_q.pendLane;
               end
               s_d.d     = data[i*DATA_W +: DATA_W];
               // lanes may differ beat by beat
               s_d.laneN = lane[i*LANES +: LANES];
            end
            // sample the word launched at the rise just passed
            if (s_q.rdHist[b4sram_pkg::RD_FIRST_BEAT + i])
            begin
               s_d.rdWord  = link.q;
               s_d.rdValid = 1'b1;
            end
         end
      end
      if (!rst_b)
      begin
         s_d = '0;
         s_d.rdSelN = 1'b1;
         s_d.wrSelN = 1'b1;
         s_d.laneN  = '1;
         // link clock keeps running so the device sees its reset
         s_d.clk    = 1'b1;
         if (s_q.clk)
         begin
            s_d.clk = 1'b0;
         end
         s_d.single = singleClock;
      end
   end

   always_ff @(posedge clock)
   begin
      s_q <= s_d;
   end

   assign link.linkClk              = s_q.clk;
   assign link.kPhase               = s_q.phase;
   assign link.readPortSelectN      = s_q.rdSelN;
   assign link.writePortSelectN     = s_q.wrSelN;
   assign link.cTieHigh             = s_q.single;
   assign link.addr                 = s_q.addr;
   assign link.d                    = s_q.d;
   assign link.byteLaneWriteSelectN = s_q.laneN;
   assign rdData                    = s_q.rdWord;
   assign rdValid                   = s_q.rdValid;
endmodule // b4sram_ctrl

// file: verification/b4sram_link_chk.sv
// Purpose: link checks between the controller and the SRAM end
// Assumes: one linkClk rise per beat, kPhase high on true rises
// Notes:   instantiated beside the link interface, no bind
module b4sram_link_chk #(
   parameter int DATA_W = 18
) (
   linkClk,              // beat clock
   rst_b,                // sync reset, active low
   kPhase,               // coming rise is a true rise
   readPortSelectN,      // read start, active low
   writePortSelectN,     // write start, active low
   cTieHigh,             // strap level
   byteLaneWriteSelectN, // lane enables, active low
   qOe                   // read word driven
);
   localparam int LANES = DATA_W / b4sram_pkg::LANE_W;
   input wire logic             linkClk;
   input wire logic             rst_b;
   input wire logic             kPhase;
   input wire logic             readPortSelectN;
   input wire logic             writePortSelectN;
   input wire logic             cTieHigh;
   input wire logic [LANES-1:0] byteLaneWriteSelectN;
   input wire logic             qOe;
   logic rdGo;
   logic wrGo;
   assign rdGo = kPhase && !readPortSelectN;
   assign wrGo = kPhase && !writePortSelectN;
   default clocking cb @(posedge linkClk); endclocking
   default disable iff (!rst_b);
   sequence s_rdStart; rdGo; endsequence
   sequence s_rdQuiet; (!rdGo)[*7]; endsequence
   property p_kAlt; kPhase |=> !kPhase; endproperty
   property p_rdSpace; s_rdStart |-> ##2 !rdGo; endproperty
   property p_wrSpace; wrGo |-> ##2 !wrGo; endproperty
   property p_rdLat; s_rdStart |-> ##4 qOe[*4]; endproperty
   property p_rdEnd; s_rdStart ##1 s_rdQuiet |=> !qOe; endproperty
   property p_qCause;
      qOe |-> $past(rdGo, 4) || $past(rdGo, 5) || $past(rdGo, 6)
              || $past(rdGo, 7);
   endproperty
   // lanes may only be enabled on the four data beats of a write
   property p_laneCause;
      !(&byteLaneWriteSelectN) |-> $past(wrGo, 2) || $past(wrGo, 3)
                                   || $past(wrGo, 4) || $past(wrGo, 5);
   endproperty
   property p_strap; $past(rst_b) |-> $stable(cTieHigh); endproperty
   a_kAlt: assert property (p_kAlt)
      else $error("two true rises in a row");
   a_rdSpace: assert property (p_rdSpace)
      else $error("reads started on consecutive true rises");
   a_wrSpace: assert property (p_wrSpace)
      else $error("writes started on consecutive true rises");
   a_rdLat: assert property (p_rdLat)
      else $error("read words not driven on beats three to six");
   a_rdEnd: assert property (p_rdEnd)
      else $error("read outputs still driven after burst");
   a_qCause: assert property (p_qCause)
      else $error("read outputs driven without a read");
   a_laneCause: assert property (p_laneCause)
      else $error("lane enabled outside write data beats");
   a_strap: assert property (p_strap)
      else $error("strap changed during operation");
   c_rdPair: cover property (s_rdStart ##2 rdGo);
endmodule // b4sram_link_chk

// file: verification/testbench.sv
// Purpose: end to end bench, controller and SRAM joined by the link
// Assumes: link clock is made by the controller from clock
// Notes:   reads are compared with a lane-masked memory model
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock;
   logic        rst_b;
   logic        clockRun;
   logic        singleClock;
   logic        cmdValid;
   logic        cmdReady;
   logic        cmdWrite;
   logic [3:0]  cmdAddr;
   logic [71:0] cmdData;
   logic [7:0]  cmdLaneN;
   logic [17:0] rdData;
   logic        rdValid;
   logic        strap;
   logic        rdyS;
   logic        sawFull;
   logic [17:0] mem [16];
   logic [17:0] rdq [$];
   int          error_cnt;
   int          n_checks;
   b4sram_link_if #(.DATA_W(18), .ADDR_W(4)) lnk ();
   // ctrl and device run at their default widths, which match lnk
   b4sram_ctrl b4sram_ctrl_inst (
      .clock(clock), .rst_b(rst_b), .clockRun(clockRun),
      .singleClock(singleClock), .cmdValid(cmdValid), .cmdReady(cmdReady),
      .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
      .cmdLaneN(cmdLaneN), .rdData(rdData), .rdValid(rdValid),
      .link(lnk.ctl));
   b4sram_device b4sram_device_inst (
      .link(lnk.dev), .rst_b(rst_b), .singleClockMode(strap));
   b4sram_link_chk #(.DATA_W(18)) b4sram_link_chk_inst (
      .linkClk(lnk.linkClk), .rst_b(rst_b), .kPhase(lnk.kPhase),
      .readPortSelectN(lnk.readPortSelectN),
      .writePortSelectN(lnk.writePortSelectN), .cTieHigh(lnk.cTieHigh),
      .byteLaneWriteSelectN(lnk.byteLaneWriteSelectN), .qOe(lnk.qOe));
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // sample away from the rising edge so flop updates never race
   always @(negedge clock)
   begin
      rdyS <= cmdReady;
      if (cmdReady === 1'b0) sawFull <= 1'b1;
      if (rdValid === 1'b1) rdq.push_back(rdData);
   end
   task automatic chk(input string nm, input logic [17:0] e,
                      input logic [17:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // valid stays high on return so calls can follow back to back
   task automatic send(input logic w, input logic [3:0] a,
                       input logic [71:0] dt, input logic [7:0] ln);
      int i;
      cmdValid <= 1'b1;
      cmdWrite <= w;
      cmdAddr <= a;
      cmdData <= dt;
      cmdLaneN <= ln;
      i = 0;
      do
      begin
         @(posedge clock);
         i++;
      end
      while (rdyS !== 1'b1 && i < 200);
      if (rdyS !== 1'b1)
      begin
         error_cnt++;
         $display("ERROR cmdReady expected 1 seen %b", rdyS);
      end
      if (w)
         for (int b = 0; b < 4; b++)
            for (int j = 0; j < 2; j++)
               if (!ln[b*2+j]) mem[4'(a+b)][j*9+:9] = dt[b*18+j*9+:9];
   endtask
   task automatic rest(input int n);
      cmdValid <= 1'b0;
      repeat (n) @(posedge clock);
   endtask
   task automatic rdback(input logic [3:0] a);
      int i;
      send(1'b0, a, 72'h0, 8'hff);
      rest(1);
      i = 0;
      while (rdq.size() < 4 && i < 100)
      begin
         @(posedge clock);
         i++;
      end
      for (int b = 0; b < 4; b++)
         chk("rdData", mem[4'(a+b)], rdq.size() ? rdq.pop_front() : 'x);
   endtask
   task automatic reboot(input logic s);
      rst_b <= 1'b0;
      singleClock <= s;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      foreach (mem[k]) mem[k] = 18'h0;
      rdq.delete();
      // device leaves reset only after its three-stage resync
      repeat (12) @(posedge clock);
      chk("singleClockMode", 18'(s), 18'(strap));
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      rst_b = 1'b0;
      clockRun = 1'b1;
      singleClock = 1'b1;
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdAddr = 4'h0;
      cmdData = 72'h0;
      cmdLaneN = 8'hff;
      sawFull = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      reboot(1'b1);
      rdback(4'h0);
      send(1'b1, 4'h4, 72'h123456789abcdef012, 8'h00);
      rdback(4'h4);
      send(1'b1, 4'he, 72'hfedcba98765432100f, 8'h00);
      rdback(4'he);
      // beat0 both lanes, beat1 upper, beat2 lower, beat3 none
      send(1'b1, 4'h4, 72'h3ffffffffffffffff0, 8'b11_10_01_00);
      rdback(4'h4);
      rest(20);
      sawFull <= 1'b0;
      for (int k = 0; k < 6; k++)
         send(1'b1, 4'(k * 2), {4{18'(k * 4'h9 + 4'h5)}}, 8'(k));
      rest(1);
      chk("cmdReady refused", 18'h1, 18'(sawFull));
      for (int k = 0; k < 4; k++)
      begin
         send(1'b1, 4'(k * 4), {4{18'(k + 4'ha)}}, 8'h00);
         rdback(4'(k * 4));
      end
      rest(20);
      clockRun <= 1'b0;
      repeat (10) @(posedge clock);
      repeat (8)
      begin
         @(negedge clock);
         chk("linkClk", 18'h1, 18'(lnk.linkClk));
      end
      @(posedge clock);
      clockRun <= 1'b1;
      rest(4);
      rdback(4'h8);
      reboot(1'b0);
      rdback(4'h4);
      final_report();
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      final_report();
   end
endmodule // testbench
